// ===== verilog/pdm_params.svh
// Purpose: offsets, reset values and timing counts of the memory decode block
// Assumes: register indices are word indices, byte address is four times the index
// Notes: definitions only
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH

// register indices
`define PDM_IDX_CLKCTL  8'h8E
`define PDM_IDX_ROMLIM  8'hC2
`define PDM_IDX_PWRMGT  8'hC4
`define PDM_IDX_UNLOCK  8'hC7
`define PDM_IDX_STATUS  8'hE0

// reset values
`define PDM_RST_CLKCTL  8'h01
`define PDM_RST_PWRMGT  8'h40
`define PDM_RST_ROMLIM  3'h5

// field positions and codes
`define PDM_STRETCH_MSB 2
`define PDM_REGION_MSB  1
`define PDM_ROMSEL_MSB  2
`define PDM_ROMSEL_RSVD 3'h6
`define PDM_REGION_EXT  2'h0
`define PDM_REGION_SRAM 2'h1
`define PDM_REGION_LOCK 2'h3

// timed access keys
`define PDM_KEY_FIRST   8'hAA
`define PDM_KEY_SECOND  8'h55

// address map
`define PDM_ROM_1KB     17'h00400
`define PDM_SRAM_TOP    16'h03FF
`define PDM_LOCK_ADDR   16'hFFFC
`define PDM_SRAM_WORDS  1024

// timing
`define PDM_CLK_NS      40
`define PDM_UNLOCK_NS   480
`define PDM_UNLOCK_CYC  (`PDM_UNLOCK_NS / `PDM_CLK_NS)
`define PDM_CLK_PER_MC  4
`define PDM_MOVE_MC     2
`define PDM_FETCH_LAST  6'd5

// bus answers
`define PDM_RESP_OKAY   2'h0
`define PDM_RESP_DECERR 2'h3

`endif

// ===== verilog/pdm_pkg.sv
// Purpose: types of the memory decode block
// Assumes: nothing
// Notes: constants live in pdm_params.svh
package pdm_pkg;

	// sequencer states
	typedef enum {ST_IDLE, ST_FETCH, ST_MOVE} seq_e;

	// where a data move goes
	typedef enum logic [1:0] {TGT_EXT, TGT_SRAM, TGT_LOCK, TGT_NONE} target_e;

endpackage

// ===== verilog/program_data_memory_decode.sv
// Purpose: program fetch and data move decode with external bus timing
// Assumes: 4 clocks per machine cycle; core requests are one-cycle pulses
// Notes: registers over AXI4-Lite, one word per register, data in bits 7:0
//
// Behaviour
// R1 - fetch on-chip up to the selected limit, above it from the external bus
// R2 - three-bit size code picks 0/1/2/4/8/16KB; codes 6 and 7 are invalid
// R3 - after reset the on-chip program limit is the full 16KB
// R4 - size code is written only inside the timed-access unlock window
// R5 - a new size limit applies to the very next fetch
// R6 - software changes the limit only from code that stays on one side
// R7 - force-external pin low sends every fetch to the external bus
// R8 - program store strobe goes low during external fetches
// R9 - port 0 carries low address and data, port 2 the high address
// R10 - region code 00, the reset value, sends every data move outside
// R11 - region code 01 maps 0000h-03FFh to SRAM, the rest outside
// R12 - region code 11: SRAM low 1KB, FFFCh lock byte, rest no access
// R13 - lock byte bits 2-0 show programmed lock bits, read only
// R14 - region select bits sit in power management bits 1-0, writable anytime
// R15 - moves to internal SRAM always take two machine cycles
// R16 - external moves take two machine cycles plus the stretch value
// R17 - stretch value is one after reset, three-cycle external moves
// R18 - stretch above zero widens strobes and adds one clock setup and hold
// R19 - stretch value is held in clock control bits 2-0
// R20 - stretch never changes external program fetch timing
// R21 - every access decodes against current settings and the live pin
`timescale 1ns/1ps
`default_nettype none
`include "pdm_params.svh"

module program_data_memory_decode (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// core program fetch
	input  wire logic        fetch_req,
	input  wire logic [15:0] fetch_addr,
	output logic             fetch_done,
	output logic             fetch_from_rom,
	output logic [7:0]       fetch_data,
	// core data move
	input  wire logic        move_req,
	input  wire logic        move_write,
	input  wire logic [15:0] move_addr,
	input  wire logic [7:0]  move_wdata,
	output logic             move_done,
	output logic [7:0]       move_rdata,
	output logic [1:0]       move_target,
	// pins
	input  wire logic        force_external_fetch_n,
	input  wire logic [2:0]  security_lock,
	input  wire logic [7:0]  low_addr_data_port_in,
	output logic [7:0]       low_addr_data_port_out,
	output logic             low_addr_data_port_oe,
	output logic [7:0]       high_addr_port_out,
	output logic             high_addr_port_oe,
	output logic             addr_latch_en,
	output logic             program_store_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n
);

	// state
	logic              ea_meta_reg;
	logic              ea_sync_reg;
	logic [2:0]        lock_meta_reg;
	logic [2:0]        lock_sync_reg;
	logic [7:0]        p0_meta_reg;
	logic [7:0]        p0_sync_reg;
	logic [11:0]       aw_addr_reg;
	logic              aw_have_reg;
	logic [7:0]        w_data_reg;
	logic              w_strb_reg;
	logic              w_have_reg;
	logic [7:0]        clkctl_reg;
	logic [7:0]        pwrmgt_reg;
	logic [2:0]        romsel_reg;
	logic              armed_reg;
	logic [4:0]        unlock_cnt_reg;
	pdm_pkg::seq_e     state_reg;
	pdm_pkg::target_e  tgt_reg;
	logic [5:0]        cnt_reg;
	logic [5:0]        last_reg;
	logic [15:0]       addr_reg;
	logic [7:0]        wd_reg;
	logic              wr_reg;
	logic [2:0]        sl_reg;
	logic [7:0]        sram_q_reg;
	logic [7:0]        ext_q_reg;
	logic              ext_fetch_reg;
	logic [7:0]        sram [0:`PDM_SRAM_WORDS-1];

	// on-chip program top, exclusive; reserved codes never get stored
	function automatic logic [16:0] rom_top_f(input logic [2:0] sel);
		rom_top_f = (sel == 3'h0) ? 17'h00000 : (`PDM_ROM_1KB << (sel - 3'h1));
	endfunction

	// data move decode against the current region code
	function automatic pdm_pkg::target_e move_tgt_f(input logic [15:0] a,
	                                                input logic [1:0] rg);
		logic lo;
		lo = (a <= `PDM_SRAM_TOP);
		case (rg)
			`PDM_REGION_SRAM: move_tgt_f = lo ? pdm_pkg::TGT_SRAM : pdm_pkg::TGT_EXT;
			`PDM_REGION_LOCK: move_tgt_f = lo ? pdm_pkg::TGT_SRAM :
				(a == `PDM_LOCK_ADDR) ? pdm_pkg::TGT_LOCK : pdm_pkg::TGT_NONE;
			default:          move_tgt_f = pdm_pkg::TGT_EXT;
		endcase
	endfunction

	// last clock count of a move
	function automatic logic [5:0] move_last_f(input pdm_pkg::target_e t,
	                                           input logic [2:0] s);
		if (t == pdm_pkg::TGT_EXT)
			move_last_f = 6'((`PDM_MOVE_MC + s) * `PDM_CLK_PER_MC - 1);
		else
			move_last_f = 6'(`PDM_MOVE_MC * `PDM_CLK_PER_MC - 1);
	endfunction

	// register address check, shared by both bus directions
	function automatic logic addr_ok_f(input logic [11:0] a);
		logic [7:0] i;
		i = a[9:2];
		addr_ok_f = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(i == `PDM_IDX_CLKCTL || i == `PDM_IDX_ROMLIM || i == `PDM_IDX_PWRMGT ||
			 i == `PDM_IDX_UNLOCK || i == `PDM_IDX_STATUS);
	endfunction

	// bus decode
	wire [7:0] aw_idx = aw_addr_reg[9:2];
	wire [7:0] ar_idx = araddr[9:2];
	wire       wr_go  = aw_have_reg && w_have_reg && !bvalid;
	wire       wr_ok  = addr_ok_f(aw_addr_reg);
	wire       wr_en  = wr_go && wr_ok && w_strb_reg;
	wire       unlocked = (unlock_cnt_reg != 5'h0);
	wire       busy = (state_reg != pdm_pkg::ST_IDLE);
	wire [7:0] status_byte = {2'h0, busy, ext_fetch_reg, ea_sync_reg, lock_sync_reg};
	wire [7:0] rd_byte =
		(ar_idx == `PDM_IDX_CLKCTL) ? clkctl_reg :
		(ar_idx == `PDM_IDX_ROMLIM) ? {5'h0, romsel_reg} :
		(ar_idx == `PDM_IDX_PWRMGT) ? pwrmgt_reg :
		(ar_idx == `PDM_IDX_STATUS) ? status_byte : 8'h00;

	// access decode, always from live settings [R21] [R5]
	wire [16:0]       rom_top = rom_top_f(romsel_reg);
	wire              fetch_ext = !ea_sync_reg || ({1'b0, fetch_addr} >= rom_top); // [R1] [R7]
	wire [2:0]        stretch = clkctl_reg[`PDM_STRETCH_MSB:0]; // [R19]
	wire [1:0]        region = pwrmgt_reg[`PDM_REGION_MSB:0]; // [R14]
	pdm_pkg::target_e move_tgt;
	assign move_tgt = move_tgt_f(move_addr, region); // [R10] [R11] [R12]
	wire              fetch_acc = !busy && fetch_req;
	wire              move_acc = !busy && !fetch_req && move_req;

	// bus phase decode
	wire       in_fetch = (state_reg == pdm_pkg::ST_FETCH);
	wire       in_ext = (state_reg == pdm_pkg::ST_MOVE) && (tgt_reg == pdm_pkg::TGT_EXT);
	wire       seq_last = busy && (cnt_reg == last_reg);
	wire [5:0] stb_beg = (sl_reg == 3'h0) ? 6'd2 : 6'd3; // extra setup clock [R18]
	wire [5:0] stb_w = (sl_reg == 3'h0) ? 6'd2 : {1'b0, sl_reg, 2'b00}; // [R18]
	wire [5:0] stb_end = 6'(stb_beg + stb_w - 6'd1);
	wire       stb_on = in_ext && (cnt_reg >= stb_beg) && (cnt_reg <= stb_end);
	wire       ext_cap = in_ext && (cnt_reg == 6'(stb_end + 6'd3));
	wire       p0_drive = (in_fetch || in_ext) && (cnt_reg == 6'd0 || (in_ext && wr_reg));

	// pin synchronisers, first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ea_meta_reg   <= 1'b1;
			ea_sync_reg   <= 1'b1;
			lock_meta_reg <= 3'h0;
			lock_sync_reg <= 3'h0;
			p0_meta_reg   <= 8'h00;
			p0_sync_reg   <= 8'h00;
		end else begin
			ea_meta_reg   <= force_external_fetch_n;
			ea_sync_reg   <= ea_meta_reg;
			lock_meta_reg <= security_lock;
			lock_sync_reg <= lock_meta_reg;
			p0_meta_reg   <= low_addr_data_port_in;
			p0_sync_reg   <= p0_meta_reg;
		end
	end

	// write address and data, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			awready     <= 1'b1;
			aw_addr_reg <= 12'h000;
		end else if (awvalid && awready) begin
			aw_addr_reg <= awaddr;
			aw_have_reg <= 1'b1;
			awready     <= 1'b0;
		end else if (wr_go) begin
			aw_have_reg <= 1'b0;
			awready     <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg <= 1'b0;
			wready     <= 1'b1;
			w_data_reg <= 8'h00;
			w_strb_reg <= 1'b0;
		end else if (wvalid && wready) begin
			w_data_reg <= wdata[7:0];
			w_strb_reg <= wstrb[0];
			w_have_reg <= 1'b1;
			wready     <= 1'b0;
		end else if (wr_go) begin
			w_have_reg <= 1'b0;
			wready     <= 1'b1;
		end
	end

	// write response once both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `PDM_RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= wr_ok ? `PDM_RESP_OKAY : `PDM_RESP_DECERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// read channel, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `PDM_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h000000, rd_byte}; // [R13]
			rresp   <= addr_ok_f(araddr) ? `PDM_RESP_OKAY : `PDM_RESP_DECERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// clock control and power management, freely writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clkctl_reg <= `PDM_RST_CLKCTL; // [R17]
			pwrmgt_reg <= `PDM_RST_PWRMGT; // [R10]
		end else begin
			if (wr_en && aw_idx == `PDM_IDX_CLKCTL)
				clkctl_reg <= w_data_reg; // [R19]
			if (wr_en && aw_idx == `PDM_IDX_PWRMGT)
				pwrmgt_reg <= w_data_reg; // [R14]
		end
	end

	// two-key unlock opens a short window for the size code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_reg      <= 1'b0;
			unlock_cnt_reg <= 5'h00;
		end else if (wr_en && aw_idx == `PDM_IDX_UNLOCK) begin
			armed_reg      <= (w_data_reg == `PDM_KEY_FIRST);
			unlock_cnt_reg <= (armed_reg && w_data_reg == `PDM_KEY_SECOND) ?
				5'(`PDM_UNLOCK_CYC) : 5'h00; // [R4]
		end else if (unlocked) begin
			unlock_cnt_reg <= unlock_cnt_reg - 5'h01;
		end
	end

	// size code: locked writes and reserved codes are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn)
			romsel_reg <= `PDM_RST_ROMLIM; // [R3]
		else if (wr_en && aw_idx == `PDM_IDX_ROMLIM && unlocked &&
		         w_data_reg[`PDM_ROMSEL_MSB:0] < `PDM_ROMSEL_RSVD) // [R4] [R2]
			romsel_reg <= w_data_reg[`PDM_ROMSEL_MSB:0];
	end

	// sequencer; fetch wins when both requests come together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg     <= pdm_pkg::ST_IDLE;
			tgt_reg       <= pdm_pkg::TGT_EXT;
			cnt_reg       <= 6'd0;
			last_reg      <= 6'd0;
			addr_reg      <= 16'h0000;
			wd_reg        <= 8'h00;
			wr_reg        <= 1'b0;
			sl_reg        <= 3'h0;
			ext_fetch_reg <= 1'b0;
		end else begin
			case (state_reg)
				pdm_pkg::ST_IDLE: begin
					cnt_reg <= 6'd0;
					if (fetch_acc) begin
						addr_reg      <= fetch_addr;
						ext_fetch_reg <= fetch_ext;
						last_reg      <= `PDM_FETCH_LAST; // no stretch here [R20]
						if (fetch_ext)
							state_reg <= pdm_pkg::ST_FETCH; // [R1]
					end else if (move_acc) begin
						state_reg <= pdm_pkg::ST_MOVE;
						addr_reg  <= move_addr;
						wd_reg    <= move_wdata;
						wr_reg    <= move_write;
						tgt_reg   <= move_tgt;
						sl_reg    <= stretch;
						last_reg  <= move_last_f(move_tgt, stretch); // [R15] [R16]
					end
				end
				pdm_pkg::ST_FETCH, pdm_pkg::ST_MOVE: begin
					if (seq_last)
						state_reg <= pdm_pkg::ST_IDLE;
					else
						cnt_reg <= cnt_reg + 6'd1;
				end
				default: state_reg <= pdm_pkg::ST_IDLE;
			endcase
		end
	end

	// on-chip data ram, read at request time
	always_ff @(posedge aclk) begin
		if (move_acc && move_tgt == pdm_pkg::TGT_SRAM && move_write)
			sram[move_addr[9:0]] <= move_wdata; // [R11]
		if (move_acc)
			sram_q_reg <= sram[move_addr[9:0]];
	end

	// external read capture; sync delay is why the strobe is read late
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ext_q_reg <= 8'h00;
		else if (ext_cap)
			ext_q_reg <= p0_sync_reg;
	end

	// pin drive, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_latch_en          <= 1'b0;
			program_store_strobe_n <= 1'b1;
			read_strobe_n          <= 1'b1;
			write_strobe_n         <= 1'b1;
			low_addr_data_port_out <= 8'h00;
			low_addr_data_port_oe  <= 1'b0;
			high_addr_port_out     <= 8'h00;
			high_addr_port_oe      <= 1'b0;
		end else begin
			addr_latch_en          <= (in_fetch || in_ext) && cnt_reg == 6'd0;
			program_store_strobe_n <= !(in_fetch && cnt_reg != 6'd0); // [R8]
			read_strobe_n          <= !(stb_on && !wr_reg); // [R18]
			write_strobe_n         <= !(stb_on && wr_reg); // [R18]
			low_addr_data_port_out <= (cnt_reg == 6'd0) ? addr_reg[7:0] : wd_reg; // [R9]
			low_addr_data_port_oe  <= p0_drive; // [R9]
			high_addr_port_out     <= addr_reg[15:8]; // [R9]
			high_addr_port_oe      <= in_fetch || in_ext; // [R9]
		end
	end

	// answers to the core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_done     <= 1'b0;
			fetch_from_rom <= 1'b0;
			fetch_data     <= 8'h00;
			move_done      <= 1'b0;
			move_rdata     <= 8'h00;
			move_target    <= 2'h0;
		end else begin
			fetch_done <= (fetch_acc && !fetch_ext) || (in_fetch && seq_last);
			if (fetch_acc)
				fetch_from_rom <= !fetch_ext; // [R1]
			if (in_fetch && seq_last)
				fetch_data <= p0_sync_reg;
			move_done <= (state_reg == pdm_pkg::ST_MOVE) && seq_last;
			if ((state_reg == pdm_pkg::ST_MOVE) && seq_last) begin
				move_target <= tgt_reg;
				case (tgt_reg)
					pdm_pkg::TGT_SRAM: move_rdata <= sram_q_reg;
					pdm_pkg::TGT_LOCK: move_rdata <= {5'h00, lock_sync_reg}; // [R13]
					pdm_pkg::TGT_EXT:  move_rdata <= ext_q_reg;
					default:           move_rdata <= 8'h00;
				endcase
			end
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rom_hit_a: assert property (fetch_acc && !fetch_ext |=> fetch_done && fetch_from_rom) // [R1]
		else $error("internal fetch not answered next cycle");
	rom_sel_a: assert property (romsel_reg < `PDM_ROMSEL_RSVD) // [R2]
		else $error("reserved size code stored");
	rom_rst_a: assert property ($rose(aresetn) |-> romsel_reg == `PDM_RST_ROMLIM) // [R3]
		else $error("size code not full after reset");
	size_lock_a: assert property ($changed(romsel_reg) |-> $past(unlocked)) // [R4]
		else $error("size code changed while locked");
	force_ext_a: assert property (fetch_acc && !ea_sync_reg |=> in_fetch) // [R7]
		else $error("forced fetch stayed internal");
	store_strobe_a: assert property ($fell(program_store_strobe_n) |-> // [R8]
		!program_store_strobe_n [*5] ##1 program_store_strobe_n)
		else $error("program strobe width wrong");
	bus_owner_a: assert property (!program_store_strobe_n || !read_strobe_n |-> // [R9]
		high_addr_port_oe)
		else $error("high address not driven during access");
	data_dflt_a: assert property (move_acc && region == `PDM_REGION_EXT |=> // [R10]
		tgt_reg == pdm_pkg::TGT_EXT)
		else $error("default region move not external");
	no_access_a: assert property (state_reg == pdm_pkg::ST_MOVE && // [R12]
		tgt_reg == pdm_pkg::TGT_NONE |-> read_strobe_n && write_strobe_n && !high_addr_port_oe)
		else $error("reserved address reached the bus");
	sram_time_a: assert property (move_acc && move_tgt != pdm_pkg::TGT_EXT |-> // [R15]
		##9 move_done)
		else $error("internal move not two machine cycles");
	ext_long_a: assert property (move_acc && move_tgt == pdm_pkg::TGT_EXT && // [R16]
		stretch == 3'h7 |-> ##37 move_done)
		else $error("stretch seven move not nine machine cycles");
	stretch_rst_a: assert property ($rose(aresetn) |-> stretch == 3'h1) // [R17]
		else $error("stretch not one after reset");
	rd_wide_a: assert property ($fell(read_strobe_n) && sl_reg == 3'h1 |-> // [R18]
		!read_strobe_n [*4] ##1 read_strobe_n)
		else $error("stretch one strobe not four clocks");
	fetch_time_a: assert property (fetch_acc && fetch_ext |-> ##7 fetch_done) // [R20]
		else $error("external fetch time wrong");

	ext_fetch_c: cover property (fetch_acc && fetch_ext ##7 fetch_done);
	sram_move_c: cover property (move_acc && move_tgt == pdm_pkg::TGT_SRAM);
	lock_read_c: cover property (move_done && move_target == 2'h2);
	long_move_c: cover property (move_acc && move_tgt == pdm_pkg::TGT_EXT && stretch == 3'h7);

endmodule
`default_nettype wire

// ===== testbench/ext_mem_model.sv
// Purpose: external program and data memory on the multiplexed bus
// Assumes: address is latched while addr_latch_en is high
// Notes: a released bus shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	// clock
	input  wire logic       aclk,
	// bus from the block
	input  wire logic       ale,
	input  wire logic [7:0] lo_out,
	input  wire logic       lo_oe,
	input  wire logic [7:0] hi_out,
	input  wire logic       program_store_strobe_n_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	// resolved low port level
	output logic [7:0]      lo_level
);
	logic [7:0]  mem [0:65535];
	logic [15:0] lat;
	logic [7:0]  last = 8'h00;
	logic        drv_q = 1'b0;
	wire         drv = !program_store_strobe_n_n || !rd_n || drv_q;
	// per-address pattern so a wrong address shows up as wrong data
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h3C;
		end
	end
	// data held one clock past the strobe as output hold, then let go
	assign lo_level = lo_oe ? lo_out : (drv ? mem[lat] : ~last);
	// address latch, hold tracking and write capture
	always @(posedge aclk) begin
		if (ale)
			lat <= {hi_out, lo_level};
		if (!wr_n)
			mem[lat] <= lo_level;
		drv_q <= !program_store_strobe_n_n || !rd_n;
		last <= lo_level;
	end
endmodule
`default_nettype wire

// ===== testbench/test_program_data_memory_decode.sv
// Purpose: register, fetch and data move checks of the memory decode block
// Assumes: external memory model on the bus pins
// Notes: counts are taken from strobes sampled on each rising edge
`timescale 1ns/1ps
`default_nettype none
module test_program_data_memory_decode;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic fetch_req = 0, move_req = 0, move_write = 0, force_external_fetch_n = 1;
	logic [2:0] lock_pins = 3'h6;
	logic [15:0] fetch_addr = 0, move_addr = 0, lim;
	logic [7:0] move_wdata = 0, p0_level, fetch_data, move_rdata;
	logic [7:0] low_addr_data_port_out, high_addr_port_out;
	logic awready, wready, bvalid, arready, rvalid, fetch_done, fetch_from_rom, move_done;
	logic low_addr_data_port_oe, high_addr_port_oe, addr_latch_en;
	logic program_store_strobe_n, read_strobe_n, write_strobe_n;
	logic [1:0] bresp, rresp, move_target;
	int n_errors = 0, n_tests = 0, n_program_store_strobe_n = 0, n_stb = 0;

	program_data_memory_decode u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fetch_req, .fetch_addr,
		.fetch_done, .fetch_from_rom, .fetch_data, .move_req, .move_write, .move_addr,
		.move_wdata, .move_done, .move_rdata, .move_target, .force_external_fetch_n,
		.security_lock(lock_pins), .low_addr_data_port_in(p0_level), .low_addr_data_port_out,
		.low_addr_data_port_oe, .high_addr_port_out, .high_addr_port_oe, .addr_latch_en,
		.program_store_strobe_n, .read_strobe_n, .write_strobe_n);

	ext_mem_model u_mem (.aclk(aclk), .ale(addr_latch_en), .lo_out(low_addr_data_port_out),
		.lo_oe(low_addr_data_port_oe), .hi_out(high_addr_port_out),
		.program_store_strobe_n_n(program_store_strobe_n), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
		.lo_level(p0_level));

	// 25 MHz clock
	always #20 aclk = ~aclk;

	// strobe cycle counters, read before and after each access
	always @(posedge aclk) begin
		if (!program_store_strobe_n)
			n_program_store_strobe_n <= n_program_store_strobe_n + 1;
		if (!read_strobe_n || !write_strobe_n)
			n_stb <= n_stb + 1;
	end

	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got %0h exp %0h", $time, g, e);
		end
	endtask

	// write address and data offered together, each released once taken
	task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= {2'h0, i, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready === 1'h1)
				awvalid <= 1'h0;
			if (wready === 1'h1)
				wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] i, input logic [31:0] ev, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {2'h0, i, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready === 1'h1)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, ev);
		chk(rresp, er);
	endtask

	// size writes only work right after the two-key unlock
	task automatic sl(input logic [7:0] c);
		wr(8'hC7, 8'hAA, 2'h0);
		wr(8'hC7, 8'h55, 2'h0);
		wr(8'hC2, c, 2'h0);
	endtask

	// one fetch; edges counted from the taking edge to the done sample
	task automatic fe(input logic [15:0] a, input logic rom);
		int n;
		int p;
		@(posedge aclk);
		fetch_req <= 1'h1;
		fetch_addr <= a;
		p = n_program_store_strobe_n;
		@(posedge aclk);
		fetch_req <= 1'h0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (fetch_done !== 1'h1 && n < 40);
		// the strobe sample of the done edge lands in the counter one edge later
		@(posedge aclk);
		chk(n, rom ? 1 : 7);
		chk(fetch_from_rom, rom);
		chk(n_program_store_strobe_n - p, rom ? 0 : 5);
		if (!rom)
			chk(fetch_data, pat(a));
	endtask

	task automatic mv(input logic w, input logic [15:0] a, input logic [7:0] v, input int ec,
			input logic [1:0] et, input logic [7:0] ev, input int es);
		int n;
		int s;
		@(posedge aclk);
		move_req <= 1'h1;
		move_write <= w;
		move_addr <= a;
		move_wdata <= v;
		s = n_stb;
		@(posedge aclk);
		move_req <= 1'h0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (move_done !== 1'h1 && n < 80);
		chk(n, ec);
		chk(move_target, et);
		chk(n_stb - s, es);
		if (!w)
			chk(move_rdata, ev);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard at 20000 cycles, well beyond the under one thousand cycles of the sequence
	initial begin
		#(40 * 20000);
		n_errors++;
		test_done;
	end

	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rd(8'h8E, 32'h01, 2'h0);
		rd(8'hC4, 32'h40, 2'h0);
		rd(8'hC2, 32'h05, 2'h0);
		rd(8'h10, 32'h00, 2'h3);
		fe(16'h3FFF, 1'h1);
		fe(16'h4000, 1'h0);
		wr(8'hC2, 8'h01, 2'h0);
		rd(8'hC2, 32'h05, 2'h0);
		$display("reset and lock test done");
		for (int c = 0; c < 6; c++) begin
			lim = (c == 0) ? 16'hFFFF : (16'h0400 << (c - 1)) - 16'h0001;
			sl(c[7:0]);
			rd(8'hC2, c, 2'h0);
			if (c > 0)
				fe(lim, 1'h1);
			fe(lim + 16'h0001, 1'h0);
		end
		sl(8'h06);
		rd(8'hC2, 32'h05, 2'h0);
		@(posedge aclk);
		force_external_fetch_n <= 1'h0;
		repeat (3) @(posedge aclk);
		fe(16'h0000, 1'h0);
		rd(8'hE0, 32'h16, 2'h0);
		force_external_fetch_n <= 1'h1;
		repeat (3) @(posedge aclk);
		fe(16'h0000, 1'h1);
		$display("program limit test done");
		mv(1'h0, 16'h0010, 8'h00, 13, 2'h0, pat(16'h0010), 4);
		for (int s = 0; s < 8; s++) begin
			wr(8'h8E, s[7:0], 2'h0);
			mv(1'h0, 16'h1234, 8'h00, 4 * (2 + s) + 1, 2'h0, pat(16'h1234),
				(s == 0) ? 2 : 4 * s);
		end
		fe(16'h4000, 1'h0);
		mv(1'h1, 16'h2000, 8'hA5, 37, 2'h0, 8'h00, 28);
		mv(1'h0, 16'h2000, 8'h00, 37, 2'h0, 8'hA5, 28);
		$display("stretch test done");
		wr(8'hC4, 8'h41, 2'h0);
		mv(1'h1, 16'h03FF, 8'h5A, 9, 2'h1, 8'h00, 0);
		mv(1'h0, 16'h03FF, 8'h00, 9, 2'h1, 8'h5A, 0);
		mv(1'h0, 16'h0400, 8'h00, 37, 2'h0, pat(16'h0400), 28);
		wr(8'hC4, 8'h43, 2'h0);
		mv(1'h0, 16'hFFFC, 8'h00, 9, 2'h2, 8'h06, 0);
		mv(1'h1, 16'hFFFC, 8'hFF, 9, 2'h2, 8'h00, 0);
		lock_pins <= 3'h3;
		mv(1'h0, 16'hFFFC, 8'h00, 9, 2'h2, 8'h03, 0);
		mv(1'h0, 16'hFFFB, 8'h00, 9, 2'h3, 8'h00, 0);
		mv(1'h0, 16'h03FF, 8'h00, 9, 2'h1, 8'h5A, 0);
		$display("data region test done");
		test_done;
	end
endmodule
`default_nettype wire
